// ==== design/sio_defs.svh ====
// Purpose: Constants for the shared I/O port with change notification.
// Assumes: One 16-bit port, one system clock, no register bus.
// Notes: Widths, reset values and pin masks follow.
`ifndef SIO_DEFS_SVH
`define SIO_DEFS_SVH

`define SIO_PORT_WIDTH      16
`define SIO_CN_PINS         21
`define SIO_CN_LO_WIDTH     16
`define SIO_REMAP_MAX       16
`define SIO_DIR_RESET       16'hffff
`define SIO_LATCH_RESET     16'h0000
`define SIO_ODC_RESET       16'h0000
`define SIO_ANALOG_RESET    16'h0000
`define SIO_CN_RESET        21'h000000
`define SIO_IMPL_MASK       16'hffff
`define SIO_ANALOG_MASK     16'h000f
`define SIO_INPUT_ONLY_MASK 16'h0000

`endif

// ==== design/sio_pkg.sv ====
// Purpose: Types shared by the shared I/O port files.
// Assumes: Constants come from sio_defs.svh.
// Notes: Holds the register select encoding of the software access port.
`default_nettype none
package sio_pkg;
  typedef enum logic [2:0] {
    SIO_SEL_DIR    = 3'h0,
    SIO_SEL_LATCH  = 3'h1,
    SIO_SEL_LEVEL  = 3'h2,
    SIO_SEL_ODC    = 3'h3,
    SIO_SEL_ANALOG = 3'h4
  } sio_sel_t;
endpackage
`default_nettype wire

// ==== design/sio_pin_mux.sv ====
// Purpose: One pin's output ownership multiplexers and input gating.
// Assumes: Peripheral signals are synchronous to the system clock.
// Notes: Purely combinational; the top registers the results.
`default_nettype none
module sio_pin_mux (
  input  wire logic periphEnable,
  input  wire logic periphDriving,
  input  wire logic periphData,
  input  wire logic inputOnly,
  input  wire logic portData,
  input  wire logic portIsOutput,
  input  wire logic openDrain,
  input  wire logic padLevel,
  output logic      pinOut,
  output logic      pinOe,
  output logic      periphIn
);
  logic periphOwns;
  logic dataSel;
  logic enSel;

  always_comb begin
    // Input-only sharing never competes for the output driver.
    periphOwns = periphEnable && periphDriving && !inputOnly;
    dataSel    = periphOwns ? periphData : portData;
    enSel      = periphOwns ? 1'b1 : portIsOutput;
    pinOut     = openDrain ? 1'b0 : dataSel;
    pinOe      = openDrain ? (enSel && !dataSel) : enSel;
    // The peripheral sees the pad only when the port is not driving it.
    periphIn   = (enSel && !periphOwns) ? 1'b0 : padLevel;
  end
endmodule // sio_pin_mux
`default_nettype wire

// ==== design/sio_change_notify.sv ====
// Purpose: Change-of-state detection with per-pin enables.
// Assumes: Inputs may be asynchronous and pass two synchronizer flops; sleep detection is outside.
// Notes: Flags a one-cycle request on any enabled pin change.
`default_nettype none
`include "sio_defs.svh"
module sio_change_notify #(
  parameter int PINS = `SIO_CN_PINS
) (
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic [PINS-1:0] cnLevel,
  input  wire logic [PINS-1:0] cnEnable,
  output logic                 changeEvent
);
  logic [PINS-1:0] cnSync1_reg, cnSync1_next;
  logic [PINS-1:0] cnSync2_reg, cnSync2_next;
  logic [PINS-1:0] cnPrev_reg,  cnPrev_next;

  always_comb begin
    cnSync1_next = cnLevel;
    cnSync2_next = cnSync1_reg;
    cnPrev_next  = cnSync2_reg;
    changeEvent  = |((cnSync2_reg ^ cnPrev_reg) & cnEnable);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnSync1_reg <= '0;
      cnSync2_reg <= '0;
      cnPrev_reg  <= '0;
    end else begin
      cnSync1_reg <= cnSync1_next;
      cnSync2_reg <= cnSync2_next;
      cnPrev_reg  <= cnPrev_next;
    end
  end
endmodule // sio_change_notify
`default_nettype wire

// ==== design/sio_port.sv ====
// Purpose: Shared parallel I/O port with open drain, analog gating and change notify.
// Assumes: Software access is a write strobe, select and data, read data registered.
// Notes: All outputs come from flip-flops; all pins are inputs after reset.
`default_nettype none
`include "sio_defs.svh"
module sio_port #(
  parameter int          WIDTH       = `SIO_PORT_WIDTH,
  parameter int          CN_PINS     = `SIO_CN_PINS,
  parameter int          REMAP_PINS  = `SIO_REMAP_MAX,
  parameter logic [15:0] IMPL_MASK   = `SIO_IMPL_MASK,
  parameter logic [15:0] ANALOG_MASK = `SIO_ANALOG_MASK,
  parameter logic [15:0] INPUT_ONLY  = `SIO_INPUT_ONLY_MASK
) (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   writeStrobe,
  input  wire logic                   readStrobe,
  input  wire sio_pkg::sio_sel_t      regSelect,
  input  wire logic [WIDTH-1:0]       writeData,
  output logic      [WIDTH-1:0]       readData,
  input  wire logic [WIDTH-1:0]       periphEnable,
  input  wire logic [WIDTH-1:0]       periphDriving,
  input  wire logic [WIDTH-1:0]       periphData,
  output logic      [WIDTH-1:0]       periphIn,
  input  wire logic [WIDTH-1:0]       padIn,
  output logic      [WIDTH-1:0]       padOut,
  output logic      [WIDTH-1:0]       padOe,
  input  wire logic [CN_PINS-1:0]     change_notify_pin,
  input  wire logic [15:0]            change_irq_enable_lo,
  input  wire logic [CN_PINS-17:0]    change_irq_enable_hi,
  input  wire logic [15:0]            weak_pullup_enable_lo,
  input  wire logic [CN_PINS-17:0]    weak_pullup_enable_hi,
  output logic      [CN_PINS-1:0]     pullupOn,
  output logic                        input_change_notify
);
  // The logic serves one 16-bit port and a change-notify group wider than the low register.
  if (WIDTH != 16) begin : g_bad_width
    $error("sio_port WIDTH must be 16");
  end

  if (CN_PINS <= 16 || CN_PINS > 32) begin : g_bad_cn_pins
    $error("sio_port CN_PINS must be 17 to 32");
  end

  if (REMAP_PINS < 0 || REMAP_PINS > `SIO_REMAP_MAX) begin : g_bad_remap
    $error("sio_port REMAP_PINS above the remappable limit");
  end

  if ((ANALOG_MASK & ~IMPL_MASK) != 16'h0000) begin : g_bad_analog
    $error("sio_port ANALOG_MASK names unimplemented pins");
  end

  if ((INPUT_ONLY & ~IMPL_MASK) != 16'h0000) begin : g_bad_input_only
    $error("sio_port INPUT_ONLY names unimplemented pins");
  end

  localparam logic [WIDTH-1:0] IMPL = IMPL_MASK[WIDTH-1:0];

  logic [WIDTH-1:0] pin_direction_reg,     pin_direction_next;
  logic [WIDTH-1:0] output_latch_reg,      output_latch_next;
  logic [WIDTH-1:0] open_drain_ctrl_reg,   open_drain_ctrl_next;
  logic [WIDTH-1:0] analog_pin_config_reg, analog_pin_config_next;
  logic [WIDTH-1:0] pin_level_reg,         pin_level_next;
  logic [WIDTH-1:0] readData_reg,          readData_next;
  logic [WIDTH-1:0] padOut_reg,            padOut_next;
  logic [WIDTH-1:0] padOe_reg,             padOe_next;
  logic [WIDTH-1:0] periphIn_reg,          periphIn_next;
  logic [CN_PINS-1:0] pullup_reg,          pullup_next;
  logic               irq_reg,             irq_next;
  logic [WIDTH-1:0]   muxOut;
  logic [WIDTH-1:0]   muxOe;
  logic [WIDTH-1:0]   muxIn;
  logic [WIDTH-1:0]   isAnalog;
  logic               wrDir;
  logic               wrLatch;
  logic               wrOdc;
  logic               wrAnalog;
  logic [WIDTH-1:0]   readSel;
  logic [CN_PINS-1:0] cnEnable;
  logic               changeEvent;

  always_comb begin
    isAnalog = ANALOG_MASK[WIDTH-1:0] & ~analog_pin_config_reg;
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      sio_pin_mux u_mux (
        .periphEnable (periphEnable[gi]),
        .periphDriving(periphDriving[gi]),
        .periphData   (periphData[gi]),
        .inputOnly    (INPUT_ONLY[gi]),
        .portData     (output_latch_reg[gi]),
        .portIsOutput (~pin_direction_reg[gi] & IMPL[gi]),
        .openDrain    (open_drain_ctrl_reg[gi]),
        .padLevel     (padIn[gi]),
        .pinOut       (muxOut[gi]),
        .pinOe        (muxOe[gi]),
        .periphIn     (muxIn[gi])
      );
    end
  endgenerate

  always_comb begin
    cnEnable = {change_irq_enable_hi, change_irq_enable_lo};
  end

  sio_change_notify #(.PINS(CN_PINS)) u_cn (
    .clock      (clock),
    .reset      (reset),
    .cnLevel    (change_notify_pin),
    .cnEnable   (cnEnable),
    .changeEvent(changeEvent)
  );

  // One register is written per strobe; select codes without a register write nothing.
  always_comb begin
    wrDir    = 1'b0;
    wrLatch  = 1'b0;
    wrOdc    = 1'b0;
    wrAnalog = 1'b0;
    if (writeStrobe) begin
      case (regSelect)
        sio_pkg::SIO_SEL_DIR: begin
          wrDir = 1'b1;
        end
        sio_pkg::SIO_SEL_LATCH, sio_pkg::SIO_SEL_LEVEL: begin
          wrLatch = 1'b1;
        end
        sio_pkg::SIO_SEL_ODC: begin
          wrOdc = 1'b1;
        end
        sio_pkg::SIO_SEL_ANALOG: begin
          wrAnalog = 1'b1;
        end
        default: begin
          wrDir = 1'b0;
        end
      endcase
    end
  end

  // Unimplemented bits are held at zero; the IMPL gating on portIsOutput and padOe keeps them from turning into outputs.
  always_comb begin
    pin_direction_next = pin_direction_reg;
    if (wrDir) begin
      pin_direction_next = writeData & IMPL;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_direction_reg <= `SIO_DIR_RESET & IMPL_MASK;
    end else begin
      pin_direction_reg <= pin_direction_next;
    end
  end

  // Level writes land here too, so a read-modify-write of the level register keeps the latch sane.
  always_comb begin
    output_latch_next = output_latch_reg;
    if (wrLatch) begin
      output_latch_next = writeData & IMPL;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      output_latch_reg <= `SIO_LATCH_RESET;
    end else begin
      output_latch_reg <= output_latch_next;
    end
  end

  // Open drain acts on the pad driver, so it applies whoever owns the pin.
  always_comb begin
    open_drain_ctrl_next = open_drain_ctrl_reg;
    if (wrOdc) begin
      open_drain_ctrl_next = writeData & IMPL;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      open_drain_ctrl_reg <= `SIO_ODC_RESET;
    end else begin
      open_drain_ctrl_reg <= open_drain_ctrl_next;
    end
  end

  // Bits without an analog function stay zero and read back as zero.
  always_comb begin
    analog_pin_config_next = analog_pin_config_reg;
    if (wrAnalog) begin
      analog_pin_config_next = writeData & ANALOG_MASK[WIDTH-1:0];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      analog_pin_config_reg <= `SIO_ANALOG_RESET;
    end else begin
      analog_pin_config_reg <= analog_pin_config_next;
    end
  end

  always_comb begin
    // Sampled pin levels; analog pins and missing bits read low.
    pin_level_next = padIn & IMPL & ~isAnalog;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_level_reg <= '0;
    end else begin
      pin_level_reg <= pin_level_next;
    end
  end

  // Select codes without a register read as zero.
  always_comb begin
    case (regSelect)
      sio_pkg::SIO_SEL_DIR:    readSel = pin_direction_reg & IMPL;
      sio_pkg::SIO_SEL_LATCH:  readSel = output_latch_reg & IMPL;
      sio_pkg::SIO_SEL_LEVEL:  readSel = pin_level_reg;
      sio_pkg::SIO_SEL_ODC:    readSel = open_drain_ctrl_reg;
      sio_pkg::SIO_SEL_ANALOG: readSel = analog_pin_config_reg;
      default:                 readSel = '0;
    endcase
  end

  always_comb begin
    readData_next = readData_reg;
    if (readStrobe) begin
      readData_next = readSel;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      readData_reg <= '0;
    end else begin
      readData_reg <= readData_next;
    end
  end

  // Pad drive is registered so the pins never see mux glitches.
  always_comb begin
    padOut_next = muxOut & IMPL;
    padOe_next  = muxOe & IMPL;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      padOut_reg <= '0;
      padOe_reg  <= '0;
    end else begin
      padOut_reg <= padOut_next;
      padOe_reg  <= padOe_next;
    end
  end

  always_comb begin
    periphIn_next = muxIn & ~isAnalog;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      periphIn_reg <= '0;
    end else begin
      periphIn_reg <= periphIn_next;
    end
  end

  always_comb begin
    pullup_next = {weak_pullup_enable_hi, weak_pullup_enable_lo};
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pullup_reg <= CN_PINS'(`SIO_CN_RESET);
    end else begin
      pullup_reg <= pullup_next;
    end
  end

  always_comb begin
    irq_next = changeEvent;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  always_comb begin
    readData            = readData_reg;
    padOut              = padOut_reg;
    padOe               = padOe_reg;
    periphIn            = periphIn_reg;
    pullupOn            = pullup_reg;
    input_change_notify = irq_reg;
  end
endmodule // sio_port
`default_nettype wire

// ==== bench/sio_port_chk.sv ====
// Purpose: Port-side checks of the shared I/O port.
// Assumes: Default parameter widths.
// Notes: Bound to every sio_port instance.
`default_nettype none
module sio_port_chk (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        readStrobe,
  input wire logic [15:0] readData,
  input wire logic [15:0] periphEnable,
  input wire logic [15:0] periphDriving,
  input wire logic [15:0] periphData,
  input wire logic [15:0] periphIn,
  input wire logic [15:0] padIn,
  input wire logic [15:0] padOut,
  input wire logic [15:0] padOe,
  input wire logic [20:0] change_notify_pin,
  input wire logic [15:0] change_irq_enable_lo,
  input wire logic [4:0]  change_irq_enable_hi,
  input wire logic [15:0] weak_pullup_enable_lo,
  input wire logic [4:0]  weak_pullup_enable_hi,
  input wire logic [20:0] pullupOn,
  input wire logic        input_change_notify
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] owned;
  logic [20:0] cnEn;
  assign owned = periphEnable & periphDriving;
  assign cnEn = {change_irq_enable_hi, change_irq_enable_lo};
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  chk_reset_idle: assert property (disable iff (1'b0)
    reset |-> padOe == '0 && readData == '0) else $error("outputs active in reset");
  chk_periph_owns: assert property (1 |=>
    ((padOut ^ $past(periphData)) & $past(owned)) == '0 && (padOe & $past(owned)) == $past(owned))
    else $error("peripheral lost its pin");
  chk_periph_reads: assert property (1 |=> ((periphIn ^ $past(padIn)) & $past(owned)) == '0)
    else $error("peripheral input not pad level");
  chk_no_loop: assert property ((periphIn & padOe & ~$past(owned)) == '0)
    else $error("port output looped into peripheral");
  chk_cn_pulse: assert property (
    |((change_notify_pin ^ $past(change_notify_pin)) & cnEn) |-> ##[2:5] input_change_notify)
    else $error("change not flagged");
  chk_cn_quiet: assert property (
    !(|((change_notify_pin ^ $past(change_notify_pin)) & cnEn)) [*6] |=> !input_change_notify)
    else $error("change flag without enabled change");
  chk_pullup_copy: assert property (
    1 |=> pullupOn == $past({weak_pullup_enable_hi, weak_pullup_enable_lo}))
    else $error("pull-up state wrong");
  chk_read_stands: assert property (!readStrobe |=> $stable(readData))
    else $error("read data moved");
endmodule // sio_port_chk
bind sio_port sio_port_chk sio_port_chk_inst (.*);
`default_nettype wire

// ==== bench/sio_pads.sv ====
// Purpose: External pad model for the shared I/O port.
// Assumes: Port drive wins over the outside drive.
// Notes: An undriven line flips every cycle.
`default_nettype none
module sio_pads (
  input  wire logic        clock,
  input  wire logic [15:0] padOut,
  input  wire logic [15:0] padOe,
  input  wire logic [15:0] extVal,
  input  wire logic [15:0] extEn,
  output logic      [15:0] padIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] noise = 16'h5555;
  always @(posedge clock) noise <= ~noise;
  assign padIn = (padOe & padOut) | (~padOe & extEn & extVal) | (~padOe & ~extEn & noise);
endmodule // sio_pads
`default_nettype wire

// ==== bench/sio_port_tb.sv ====
// Purpose: Self-checking bench for the shared I/O port.
// Assumes: Pads come from sio_pads.
// Notes: Bit 15 is left unimplemented to exercise masking.
`default_nettype none
module sio_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, reset = 1'b0, writeStrobe = 1'b0, readStrobe = 1'b0, irq;
  sio_pkg::sio_sel_t regSelect = sio_pkg::SIO_SEL_DIR;
  logic [15:0] writeData = '0, readData, pEn = '0, pDrv = '0, pDat = '0, periphIn;
  logic [15:0] padIn, padOut, padOe, extVal = 16'ha5a5, extEn = 16'hffff;
  logic [15:0] enLo = '0, puLo = '0;
  logic [4:0]  enHi = '0, puHi = '0;
  logic [20:0] cnPin = '0, pullupOn;
  int          error_cnt = 0, checked = 0;
  sio_port #(.IMPL_MASK(16'h7fff)) sio_port_inst (.clock(clock), .reset(reset),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .regSelect(regSelect),
    .writeData(writeData), .readData(readData), .periphEnable(pEn), .periphDriving(pDrv),
    .periphData(pDat), .periphIn(periphIn), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .change_notify_pin(cnPin), .change_irq_enable_lo(enLo), .change_irq_enable_hi(enHi),
    .weak_pullup_enable_lo(puLo), .weak_pullup_enable_hi(puHi), .pullupOn(pullupOn),
    .input_change_notify(irq));
  sio_pads sio_pads_inst (.clock(clock), .padOut(padOut), .padOe(padOe), .extVal(extVal),
    .extEn(extEn), .padIn(padIn));
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Each access leaves an idle edge behind it, so reads never follow writes directly.
  task automatic wr(input sio_pkg::sio_sel_t s, input logic [15:0] d);
    @(posedge clock);
    writeStrobe <= 1'b1;
    regSelect <= s;
    writeData <= d;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask
  task automatic rd(input sio_pkg::sio_sel_t s, input logic [15:0] e);
    @(posedge clock);
    readStrobe <= 1'b1;
    regSelect <= s;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 chk(readData, e);
  endtask
  task automatic cn(input int i, input logic [20:0] e);
    logic [20:0] n;
    n = '0;
    @(posedge clock);
    cnPin[i] <= ~cnPin[i];
    repeat (8) begin
      @(posedge clock);
      #1 n = n + irq;
    end
    chk(n, e);
  endtask
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #25 clock = ~clock;
  end
  initial begin
    // A real rising edge on reset clears the flops before the first clock edge.
    reset <= 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    rd(sio_pkg::SIO_SEL_DIR, 16'h7fff);
    rd(sio_pkg::SIO_SEL_ANALOG, 16'h0000);
    rd(sio_pkg::SIO_SEL_LEVEL, 16'h25a0);
    $display("Test reset done");
    wr(sio_pkg::SIO_SEL_LATCH, 16'h1234);
    rd(sio_pkg::SIO_SEL_LATCH, 16'h1234);
    wr(sio_pkg::SIO_SEL_LEVEL, 16'h5678);
    rd(sio_pkg::SIO_SEL_LATCH, 16'h5678);
    extEn <= 16'h00ff;
    wr(sio_pkg::SIO_SEL_DIR, 16'h00ff);
    wr(sio_pkg::SIO_SEL_ANALOG, 16'hffff);
    repeat (2) @(posedge clock);
    #1 chk(padOe, 16'h7f00);
    chk(padOut & padOe, 16'h5600);
    rd(sio_pkg::SIO_SEL_ANALOG, 16'h000f);
    rd(sio_pkg::SIO_SEL_LEVEL, 16'h56a5);
    wr(sio_pkg::SIO_SEL_ODC, 16'hff00);
    repeat (2) @(posedge clock);
    #1 chk(padOe, 16'h2900);
    chk(padOut & 16'hff00, 16'h0000);
    wr(sio_pkg::SIO_SEL_ODC, 16'h0000);
    $display("Test port done");
    @(posedge clock);
    pEn <= 16'h0300;
    pDrv <= 16'h0100;
    pDat <= 16'h0100;
    repeat (3) @(posedge clock);
    #1 chk({padOe[9:8], padOut[9:8]}, 21'hf);
    chk(periphIn[9:8], 21'h1);
    $display("Test peripheral done");
    @(posedge clock);
    enLo <= 16'h0001;
    enHi <= 5'h10;
    puLo <= 16'h00f0;
    puHi <= 5'h01;
    cn(0, 21'h1);
    cn(1, 21'h0);
    cn(20, 21'h1);
    chk(pullupOn, 21'h0100f0);
    $display("Test change done");
    final_report();
  end
endmodule // sio_port_tb
`default_nettype wire
